// file: src/usm_pkg.sv
package usm_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_FLAGS      = 8'h0C;
  localparam logic [7:0] ADDR_RX_STATUS_CTRL    = 8'h18;
  localparam logic [7:0] ADDR_TX_BUFFER         = 8'h19;
  localparam logic [7:0] ADDR_RX_FIFO_DATA      = 8'h1A;
  localparam logic [7:0] ADDR_PERIPH_ENABLES    = 8'h8C;
  localparam logic [7:0] ADDR_TX_STATUS_CTRL    = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR      = 8'h99;

  // ==========================================================================
  // transmit status/control fields
  localparam int TXS_CLOCK_SOURCE  = 7;
  localparam int TXS_NINE_BIT      = 6;
  localparam int TXS_TX_ENABLE     = 5;
  localparam int TXS_SYNC_MODE     = 4;
  localparam int TXS_HIGH_SPEED    = 2;
  localparam int TXS_SHIFTER_EMPTY = 1;
  localparam int TXS_NINTH_BIT     = 0;

  // ==========================================================================
  // receive status/control fields
  localparam int RCS_PORT_ENABLE = 7;
  localparam int RCS_NINE_BIT    = 6;
  localparam int RCS_SINGLE      = 5;
  localparam int RCS_CONTINUOUS  = 4;
  localparam int RCS_ADDR_DETECT = 3;
  localparam int RCS_OVERRUN     = 1;
  localparam int RCS_NINTH_BIT   = 0;

  // ==========================================================================
  // flag, enable and interrupt control fields
  localparam int PF_RX_READY    = 5;
  localparam int PF_TX_EMPTY    = 4;
  localparam int IC_GLOBAL_IRQ  = 7;
  localparam int IC_PERIPH_IRQ  = 6;

  // ==========================================================================
  // reset values and sizes
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [3:0] WORD_BITS_EIGHT = 4'h8;
  localparam logic [3:0] WORD_BITS_NINE  = 4'h9;
  localparam logic [1:0] FIFO_DEPTH      = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    USM_IDLE = 2'b00,
    USM_TX   = 2'b01,
    USM_RX   = 2'b11
  } usm_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usm_bus_req_t;

  typedef struct packed {
    logic timing;
    logic timing_oe;
    logic data;
    logic data_oe;
  } usm_pins_t;

endpackage

// file: src/usm_sync_master.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// R1: half duplex; receiving and transmitting never share the data line at once.
// R2: sync mode bit and port enable together turn the pins into clock and data.
// R3: clock source select makes this end master, driving the shift clock.
// R4: shifter reloads from buffer only after last bit; empty shifter loads at once.
// R5: buffer-empty flag sets on transfer to shifter; only a buffer write clears it.
// R6: read-only shifter-empty status bit, polled only.
// R7: with transmit enabled, shifting starts when buffer holds data, first bit on rising edge.
// R8: data changes on rising edge so it is stable at the falling edge.
// R9: baud generator held reset while all three enables clear; starts at once.
// R10: clearing transmit enable aborts, resets transmitter, floats both pins; the clock pin stays driven while a receive enable is set.
// R11: a receive enable during transmit floats data; clock stays; transmitter frozen.
// R12: after a single-receive word, clear that bit and resume transmitting.
// R13: ninth transmit bit captured when the buffer moves into the shifter.
// R14: receive enabled by single or continuous bit; data sampled on falling edge.
// R15: single receives one word; continuous runs until cleared and wins over single.
// R16: finished word enters fifo if room, sets receive-ready; clears when fifo empty.
// R17: receive data register is a two-entry fifo.
// R18: full fifo at last bit sets overrun, drops word, blocks until continuous cleared.
// R19: received ninth bit travels with each fifo word and advances on data read.
// R20: flags set regardless; interrupt request only where enable bits allow.
// R21: software sets divisor, modes, enables, ninth bit, then writes data.
// R22: software clears receive enables first, reads status before data.
// R23: shift clock rate is the system clock divided by 2 x (baud divisor + 1).
module usm_sync_master (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire usm_pkg::usm_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  input  wire logic                  data_i,
  output usm_pkg::usm_pins_t         pins_o,
  output logic                       irq_o
);
  import usm_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    usm_mode_t       mode;
    logic [7:0]      baud_cnt;
    logic [7:0]      baud_divisor;
    logic            global_irq_enable;
    logic            peripheral_irq_enable;
    logic [7:0]      periph_enables;
    logic            clock_source_select;
    logic            nine_bit_transmit;
    logic            transmit_enable;
    logic            sync_mode;
    logic            high_speed;
    logic            transmit_ninth_bit;
    logic            serial_port_enable;
    logic            nine_bit_receive;
    logic            single_receive_enable;
    logic            continuous_receive_enable;
    logic            addr_detect;
    logic            overrun_error;
    logic [7:0]      transmit_buffer;
    logic            buffer_full;
    logic            transmit_buffer_empty_flag;
    logic [8:0]      transmit_shifter;
    logic [3:0]      tx_left;
    logic [8:0]      receive_shifter;
    logic [3:0]      rx_left;
    logic [1:0][8:0] receive_fifo;
    logic            fifo_head;
    logic [1:0]      fifo_count;
    logic            data_meta;
    logic            data_sync;
    usm_pins_t       pins;
    logic [7:0]      rdata;
    logic            irq;
  } usm_state_t;

  usm_state_t s_reg;
  usm_state_t s_next;

  // ==========================================================================
  // derived terms
  logic       port_on;
  logic       rx_req;
  logic       baud_run;
  logic       tick;
  logic       rx_active;
  logic       tx_active;
  logic       toggle;
  logic       rising;
  logic       falling;
  logic [3:0] tx_len;
  logic [3:0] rx_len;
  logic [8:0] rx_shift_in;
  logic [8:0] rx_word;
  logic       word_done;
  logic       fifo_full;
  logic       push;
  logic       set_overrun;
  logic       pop;
  logic       load;
  logic       push_idx;
  logic       rx_ready;
  logic       wr_rx_ctrl;

  assign port_on     = s_reg.serial_port_enable & s_reg.sync_mode & s_reg.clock_source_select; // see R2 see R3
  assign rx_req      = s_reg.single_receive_enable | s_reg.continuous_receive_enable;          // see R14
  assign baud_run    = s_reg.transmit_enable | rx_req;                                          // see R9
  assign tick        = baud_run & (s_reg.baud_cnt == REG_RESET);
  assign rx_active   = (s_reg.mode == USM_RX) & ~s_reg.overrun_error;                           // see R18
  assign tx_active   = (s_reg.mode == USM_TX) & (s_reg.tx_left != 4'h0);                        // see R7
  assign toggle      = tick & port_on & (s_reg.pins.timing | rx_active | tx_active);
  assign rising      = toggle & ~s_reg.pins.timing;
  assign falling     = toggle & s_reg.pins.timing;
  assign tx_len      = s_reg.nine_bit_transmit ? WORD_BITS_NINE : WORD_BITS_EIGHT;
  assign rx_len      = s_reg.nine_bit_receive ? WORD_BITS_NINE : WORD_BITS_EIGHT;
  assign rx_shift_in = {s_reg.data_sync, s_reg.receive_shifter[8:1]};                           // see R14
  assign rx_word     = s_reg.nine_bit_receive ? rx_shift_in : {1'b0, rx_shift_in[8:1]};
  assign word_done   = falling & rx_active & (s_reg.rx_left == 4'h1);
  assign fifo_full   = (s_reg.fifo_count == FIFO_DEPTH);
  assign push        = word_done & ~fifo_full;                                                   // see R16
  assign set_overrun = word_done & fifo_full;                                                    // see R18
  assign pop         = bus_i.rd & (bus_i.addr == ADDR_RX_FIFO_DATA) & (s_reg.fifo_count != 2'h0);
  assign load        = s_reg.transmit_enable & s_reg.buffer_full & (s_reg.tx_left == 4'h0)
                       & (s_reg.mode != USM_RX);                                                 // see R4
  assign push_idx    = s_reg.fifo_head ^ s_reg.fifo_count[0];
  assign rx_ready    = (s_reg.fifo_count != 2'h0);                                               // see R16
  assign wr_rx_ctrl  = bus_i.wr & (bus_i.addr == ADDR_RX_STATUS_CTRL);

  // ==========================================================================
  // next state
  always_comb begin
    s_next = s_reg;

    // data pin synchroniser
    s_next.data_meta = data_i;
    s_next.data_sync = s_reg.data_meta;

    // baud generator: half period is divisor plus one clocks
    if (!baud_run) begin
      s_next.baud_cnt = REG_RESET;                                           // see R9
    end else if (tick) begin
      s_next.baud_cnt = s_reg.baud_divisor;                                  // see R23
    end else begin
      s_next.baud_cnt = s_reg.baud_cnt - 8'h01;                              // see R23
    end

    // mode selection, receive before transmit
    if (!port_on) begin
      s_next.mode = USM_IDLE;
    end else if (rx_req) begin
      s_next.mode = USM_RX;                                                  // see R1 see R11
    end else if (s_reg.transmit_enable) begin
      s_next.mode = USM_TX;                                                  // see R12
    end else begin
      s_next.mode = USM_IDLE;
    end

    // shift clock
    if (!port_on || !baud_run) begin
      s_next.pins.timing = 1'b0;                                             // see R10
    end else begin
      s_next.pins.timing = s_reg.pins.timing ^ toggle;                       // see R3
    end

    // transmitter
    if (!s_reg.transmit_enable) begin
      s_next.tx_left          = 4'h0;                                        // see R10
      s_next.transmit_shifter = 9'h000;                                      // see R10
    end else if (load) begin
      s_next.transmit_shifter           = {s_reg.transmit_ninth_bit, s_reg.transmit_buffer}; // see R13
      s_next.tx_left                    = tx_len;
      s_next.buffer_full                = 1'b0;
      s_next.transmit_buffer_empty_flag = 1'b1;                              // see R5
    end else if (rising && tx_active) begin
      s_next.pins.data        = s_reg.transmit_shifter[0];                   // see R8
      s_next.transmit_shifter = {1'b0, s_reg.transmit_shifter[8:1]};
    end else if (falling && tx_active) begin
      s_next.tx_left = s_reg.tx_left - 4'h1;                                 // see R4
    end

    // receiver
    if (s_reg.mode != USM_RX) begin
      s_next.rx_left         = rx_len;
      s_next.receive_shifter = 9'h000;
    end else if (falling && rx_active) begin
      s_next.receive_shifter = rx_shift_in;                                  // see R14
      if (word_done) begin
        s_next.rx_left = rx_len;
        if (!s_reg.continuous_receive_enable) begin
          s_next.single_receive_enable = 1'b0;                               // see R12 see R15
        end
      end else begin
        s_next.rx_left = s_reg.rx_left - 4'h1;
      end
    end

    // receive fifo
    if (push) begin
      s_next.receive_fifo[push_idx] = rx_word;                               // see R17 see R19
    end
    if (pop) begin
      s_next.fifo_head = ~s_reg.fifo_head;                                   // see R19
    end
    if (push && !pop) begin
      s_next.fifo_count = s_reg.fifo_count + 2'h1;
    end else if (!push && pop) begin
      s_next.fifo_count = s_reg.fifo_count - 2'h1;
    end

    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_INTERRUPT_CONTROL: begin
          s_next.global_irq_enable     = bus_i.wdata[IC_GLOBAL_IRQ];
          s_next.peripheral_irq_enable = bus_i.wdata[IC_PERIPH_IRQ];
        end
        ADDR_RX_STATUS_CTRL: begin
          s_next.serial_port_enable        = bus_i.wdata[RCS_PORT_ENABLE];
          s_next.nine_bit_receive          = bus_i.wdata[RCS_NINE_BIT];
          s_next.single_receive_enable     = bus_i.wdata[RCS_SINGLE];
          s_next.continuous_receive_enable = bus_i.wdata[RCS_CONTINUOUS];
          s_next.addr_detect               = bus_i.wdata[RCS_ADDR_DETECT];
        end
        ADDR_TX_BUFFER: begin
          s_next.transmit_buffer            = bus_i.wdata;
          s_next.buffer_full                = 1'b1;
          s_next.transmit_buffer_empty_flag = 1'b0;                          // see R5
        end
        ADDR_PERIPH_ENABLES: begin
          s_next.periph_enables = bus_i.wdata;
        end
        ADDR_TX_STATUS_CTRL: begin
          s_next.clock_source_select = bus_i.wdata[TXS_CLOCK_SOURCE];
          s_next.nine_bit_transmit   = bus_i.wdata[TXS_NINE_BIT];
          s_next.transmit_enable     = bus_i.wdata[TXS_TX_ENABLE];
          s_next.sync_mode           = bus_i.wdata[TXS_SYNC_MODE];
          s_next.high_speed          = bus_i.wdata[TXS_HIGH_SPEED];
          s_next.transmit_ninth_bit  = bus_i.wdata[TXS_NINTH_BIT];
        end
        ADDR_BAUD_DIVISOR: begin
          s_next.baud_divisor = bus_i.wdata;
        end
        default: begin
        end
      endcase
    end

    // overrun: clearing continuous receive clears it, a new overrun wins
    if (wr_rx_ctrl && !bus_i.wdata[RCS_CONTINUOUS]) begin
      s_next.overrun_error = 1'b0;                                           // see R18
    end
    if (set_overrun) begin
      s_next.overrun_error = 1'b1;                                           // see R18
    end

    // pin enables
    s_next.pins.timing_oe = port_on & (s_reg.transmit_enable | rx_req);      // see R10 see R11
    s_next.pins.data_oe   = (s_next.mode == USM_TX) & s_next.transmit_enable; // see R1 see R11 see R12

    // interrupt request
    s_next.irq = s_reg.global_irq_enable & s_reg.peripheral_irq_enable
                 & ((s_reg.transmit_buffer_empty_flag & s_reg.periph_enables[PF_TX_EMPTY])
                    | (rx_ready & s_reg.periph_enables[PF_RX_READY]));       // see R20

    // register reads, data valid for one cycle only
    s_next.rdata = REG_RESET;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_INTERRUPT_CONTROL: begin
          s_next.rdata = {s_reg.global_irq_enable, s_reg.peripheral_irq_enable, 6'h00};
        end
        ADDR_PERIPH_FLAGS: begin
          s_next.rdata = {2'h0, rx_ready, s_reg.transmit_buffer_empty_flag, 4'h0}; // see R5 see R16
        end
        ADDR_RX_STATUS_CTRL: begin
          s_next.rdata = {s_reg.serial_port_enable, s_reg.nine_bit_receive,
                          s_reg.single_receive_enable, s_reg.continuous_receive_enable,
                          s_reg.addr_detect, 1'b0, s_reg.overrun_error,
                          s_reg.receive_fifo[s_reg.fifo_head][8]};           // see R19
        end
        ADDR_TX_BUFFER: begin
          s_next.rdata = s_reg.transmit_buffer;
        end
        ADDR_RX_FIFO_DATA: begin
          s_next.rdata = s_reg.receive_fifo[s_reg.fifo_head][7:0];           // see R17
        end
        ADDR_PERIPH_ENABLES: begin
          s_next.rdata = s_reg.periph_enables;
        end
        ADDR_TX_STATUS_CTRL: begin
          s_next.rdata = {s_reg.clock_source_select, s_reg.nine_bit_transmit,
                          s_reg.transmit_enable, s_reg.sync_mode, 1'b0, s_reg.high_speed,
                          (s_reg.tx_left == 4'h0), s_reg.transmit_ninth_bit}; // see R6
        end
        ADDR_BAUD_DIVISOR: begin
          s_next.rdata = s_reg.baud_divisor;
        end
        default: begin
          s_next.rdata = REG_RESET;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs
  assign rdata_o = s_reg.rdata;
  assign pins_o  = s_reg.pins;
  assign irq_o   = s_reg.irq;

endmodule

// file: testbench/usm_sync_master_assertions.sv
`timescale 1ns/100ps
module usm_chk (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire usm_pkg::usm_bus_req_t bus_i,
  input wire logic [7:0]            rdata_o,
  input wire logic                  data_i,
  input wire usm_pkg::usm_pins_t    pins_o,
  input wire logic                  irq_o
);
  import usm_pkg::*;
  logic [7:0] txs_q;
  logic [7:0] rcs_q;
  logic [7:0] ic_q;
  logic [7:0] pie_q;
  logic [7:0] div_q;
  logic [8:0] high_q;

  // ==========
  // shadows of written controls, length of clock high phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      txs_q  <= 8'h00;
      rcs_q  <= 8'h00;
      ic_q   <= 8'h00;
      pie_q  <= 8'h00;
      div_q  <= 8'h00;
      high_q <= 9'h000;
    end else begin
      if (bus_i.wr && bus_i.addr == ADDR_TX_STATUS_CTRL) txs_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == ADDR_RX_STATUS_CTRL) rcs_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == ADDR_INTERRUPT_CONTROL) ic_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == ADDR_PERIPH_ENABLES) pie_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == ADDR_BAUD_DIVISOR) div_q <= bus_i.wdata;
      high_q <= pins_o.timing ? high_q + 9'h001 : 9'h000;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ==========
  // properties
  rx_release_a: assert property (bus_i.wr && bus_i.addr == ADDR_RX_STATUS_CTRL
    && (bus_i.wdata[RCS_SINGLE] || bus_i.wdata[RCS_CONTINUOUS]) |-> ##[1:3] !pins_o.data_oe)
    else $error("data line still driven after receive enable");
  tx_abort_a: assert property (bus_i.wr && bus_i.addr == ADDR_TX_STATUS_CTRL
    && !bus_i.wdata[TXS_TX_ENABLE] && rcs_q[5:4] == 2'b00 |-> ##[1:3] (!pins_o.timing_oe && !pins_o.data_oe))
    else $error("pins not released after transmit disable");
  data_edge_a: assert property ($changed(pins_o.data) && pins_o.data_oe && $past(pins_o.data_oe)
    |-> $rose(pins_o.timing)) else $error("data changed away from rising clock");
  clock_hold_a: assert property ((!txs_q[TXS_TX_ENABLE] && !rcs_q[RCS_SINGLE] && !rcs_q[RCS_CONTINUOUS]) [*5]
    |-> $stable(pins_o.timing)) else $error("shift clock moved while generator idle");
  irq_gate_a: assert property (irq_o |-> $past(ic_q[IC_GLOBAL_IRQ]) && $past(ic_q[IC_PERIPH_IRQ])
    && ($past(pie_q[PF_RX_READY]) || $past(pie_q[PF_TX_EMPTY]))) else $error("interrupt without enables");
  rx_quiet_a: assert property (rcs_q[RCS_CONTINUOUS] && $past(rcs_q[RCS_CONTINUOUS], 3)
    |-> !pins_o.data_oe) else $error("data driven while receiving");
  clk_owner_a: assert property (pins_o.timing_oe |-> $past(txs_q[TXS_CLOCK_SOURCE])
    && $past(txs_q[TXS_SYNC_MODE]) && $past(rcs_q[RCS_PORT_ENABLE])) else $error("clock driven outside master mode");
  half_period_a: assert property ($fell(pins_o.timing) && txs_q[TXS_TX_ENABLE]
    |-> high_q == {1'b0, div_q} + 9'h001) else $error("clock high phase length wrong");
endmodule

bind usm_sync_master usm_chk i_chk (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .data_i(data_i), .pins_o(pins_o), .irq_o(irq_o));

// file: testbench/usm_slave_model.sv
`timescale 1ns/100ps
module usm_slave_model (
  input  wire logic       timing_i,
  input  wire logic       timing_oe_i,
  input  wire logic       data_i,
  input  wire logic       data_oe_i,
  input  wire logic       clr_i,
  input  wire logic [8:0] send_i,
  input  wire logic [3:0] nbits_i,
  output logic            line_o,
  output logic [8:0]      got_o,
  output int              cnt_o
);
  int idx = 0;

  // ==========
  // capture master data, step own data, both at the falling clock
  always @(negedge timing_i or posedge clr_i) begin
    if (clr_i) begin
      got_o <= 9'h000;
      cnt_o <= 0;
      idx   <= 0;
    end else if (data_oe_i) begin
      got_o <= {data_i, got_o[8:1]};
      cnt_o <= cnt_o + 1;
    end else if (timing_oe_i) begin
      idx <= (idx == int'(nbits_i) - 1) ? 0 : idx + 1;
    end
  end

  // line shows the bit while clocked with data released, else its inverse
  assign line_o = (timing_oe_i && !data_oe_i) ? send_i[idx] : ~send_i[idx];
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import usm_pkg::*;
  logic         clk_i = 1'b0;
  logic         reset_i = 1'b1;
  usm_bus_req_t bus = '0;
  usm_pins_t    pins;
  logic [7:0]   rdata;
  logic [7:0]   d;
  logic [8:0]   send = 9'h000;
  logic [8:0]   got;
  logic [3:0]   nbits = 4'h8;
  logic         irq;
  logic         line;
  logic         data_in;
  logic         clr = 1'b0;
  int           cnt;
  int           miscompares = 0;
  int           n_tests = 0;
  int           cycles = 0;

  assign data_in = (pins.data_oe === 1'b1) ? pins.data : line;
  usm_sync_master i_dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata), .data_i(data_in),
    .pins_o(pins), .irq_o(irq));
  usm_slave_model i_slave (.timing_i(pins.timing), .timing_oe_i(pins.timing_oe), .data_i(pins.data),
    .data_oe_i(pins.data_oe), .clr_i(clr), .send_i(send), .nbits_i(nbits), .line_o(line), .got_o(got),
    .cnt_o(cnt));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ==========
  // bus and compare tasks
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk({1'b0, d}, {1'b0, e});
  endtask
  task automatic ichk(input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk({8'h00, irq}, {8'h00, e});
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int k = 0; k < 500; k++) begin
      rd(a);
      if (d[b] === v) break;
    end
  endtask
  task automatic bits(input int n);
    for (int k = 0; k < 5000 && cnt < n; k++) @(posedge clk_i);
  endtask
  task automatic zap(input logic [8:0] s, input logic [3:0] n);
    send  <= s;
    nbits <= n;
    clr   <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      results();
    end
  end

  // ==========
  // scenarios
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    zap(9'h000, 4'h8);
    rchk(ADDR_TX_STATUS_CTRL, TX_STATUS_RESET);
    rchk(ADDR_PERIPH_FLAGS, 8'h00);
    rchk(8'h42, 8'h00);
    wr(ADDR_BAUD_DIVISOR, 8'h09);
    rchk(ADDR_BAUD_DIVISOR, 8'h09);
    wr(ADDR_RX_STATUS_CTRL, 8'h80);
    wr(ADDR_TX_STATUS_CTRL, 8'hB0);
    wr(ADDR_TX_BUFFER, 8'hA5);
    wr(ADDR_TX_BUFFER, 8'h3C);
    rchk(ADDR_PERIPH_FLAGS, 8'h00);
    rchk(ADDR_TX_STATUS_CTRL, 8'hB0);
    bits(8);
    chk(got, 9'h14A);
    rchk(ADDR_PERIPH_FLAGS, 8'h10);
    bits(16);
    chk(got >> 1, 9'h03C);
    poll(ADDR_TX_STATUS_CTRL, TXS_SHIFTER_EMPTY, 1'b1);
    chk({1'b0, d}, 9'h0B2);
    wr(ADDR_PERIPH_ENABLES, 8'h10);
    ichk(1'b0);
    wr(ADDR_INTERRUPT_CONTROL, 8'hC0);
    rchk(ADDR_INTERRUPT_CONTROL, 8'hC0);
    rchk(ADDR_PERIPH_ENABLES, 8'h10);
    ichk(1'b1);
    wr(ADDR_PERIPH_ENABLES, 8'h00);
    ichk(1'b0);
    wr(ADDR_TX_STATUS_CTRL, 8'hF1);
    zap(9'h000, 4'h8);
    wr(ADDR_TX_BUFFER, 8'h5A);
    bits(9);
    chk(got, 9'h15A);
    wr(ADDR_TX_BUFFER, 8'hFF);
    bits(12);
    wr(ADDR_TX_STATUS_CTRL, 8'h90);
    repeat (3) @(posedge clk_i);
    chk({7'h00, pins.timing_oe, pins.data_oe}, 9'h000);
    rchk(ADDR_TX_STATUS_CTRL, 8'h92);
    zap(9'h1C3, 4'h9);
    wr(ADDR_RX_STATUS_CTRL, 8'hC0);
    wr(ADDR_RX_STATUS_CTRL, 8'hD0);
    poll(ADDR_RX_STATUS_CTRL, RCS_OVERRUN, 1'b1);
    chk({1'b0, d}, 9'h0D3);
    rchk(ADDR_PERIPH_FLAGS, 8'h30);
    rchk(ADDR_RX_FIFO_DATA, 8'hC3);
    rchk(ADDR_RX_FIFO_DATA, 8'hC3);
    rchk(ADDR_PERIPH_FLAGS, 8'h10);
    wr(ADDR_RX_STATUS_CTRL, 8'h80);
    rd(ADDR_RX_STATUS_CTRL);
    chk({1'b0, d & 8'hFE}, 9'h080);
    wr(ADDR_TX_STATUS_CTRL, 8'hB0);
    zap(9'h05A, 4'h8);
    wr(ADDR_TX_BUFFER, 8'h81);
    wr(ADDR_RX_STATUS_CTRL, 8'hA0);
    poll(ADDR_RX_STATUS_CTRL, RCS_SINGLE, 1'b0);
    chk({1'b0, d & 8'hFE}, 9'h080);
    chk({8'h00, pins.data_oe}, 9'h001);
    rchk(ADDR_RX_FIFO_DATA, 8'h5A);
    poll(ADDR_TX_STATUS_CTRL, TXS_SHIFTER_EMPTY, 1'b1);
    chk(got >> 1, 9'h081);
    results();
  end
endmodule
